// *** hw/ssq_sequencer.sv ***
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Memory off: stop resets to first step
// - Memory on: stop keeps step for resume
// - Power-up always starts at first step
// - Disabled: normal mode supplies frequency
// - Enabled: step program supplies frequency
// - Jog, ext, internal, PID, tri, wind, normal
// - Cycle mode picks end-of-program behaviour
// - Cycle mode matters only when enabled
// - Pause modes: stop between steps
// - Fifteen speed setpoints, selected by step
// - Each step runs its own duration
// - Direction bit: 0 forward, 1 reverse
// - Direction word ignored when disabled
// - Bit 0 main reference, bit n step n
module ssq_sequencer
   import ssq_pkg::*;
#(
   parameter int SW = 16,
   parameter logic [SW-1:0] MAX_FREQ = SW'(40000),
   parameter int TICK_CYCLES = ssq_tick_cycles
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic fault,
   input wire logic out_at_zero,
   input wire logic jog_req,
   input wire logic [SW-1:0] jog_freq,
   input wire logic ext_ms_req,
   input wire logic [SW-1:0] ext_ms_freq,
   input wire logic pid_req,
   input wire logic [SW-1:0] pid_freq,
   input wire logic tri_req,
   input wire logic [SW-1:0] tri_freq,
   input wire logic wind_req,
   input wire logic [SW-1:0] wind_freq,
   input wire logic [SW-1:0] normal_freq,
   output logic [SW-1:0] freq_ref,
   output logic reverse,
   output logic seq_active
);
   typedef struct packed {
      logic mem;
      logic en;
      ssq_mode_t mode;
      logic [15:0] dir;
      logic [ssq_steps-1:0][SW-1:0] speed;
      logic [ssq_steps-1:0][13:0] dur;
      ssq_state_t st;
      logic [3:0] step;
      logic last;
      logic [SW-1:0] freq;
      logic rev;
      ssq_src_t src;
   } ssq_regs_t;

   ssq_regs_t r;
   ssq_regs_t next_r;
   logic tick;
   logic done;
   logic tmr_clear;
   logic wr;
   logic start_cmd;
   logic stop_cmd;
   logic halt;
   logic is_speed;
   logic is_dur;
   logic [3:0] idx;
   logic seq_on;

   function automatic logic is_pause(input ssq_mode_t m);
      return (m == ssq_once_pause) || (m == ssq_repeat_pause);
   endfunction : is_pause

   ////////////////////////////////////////////////////////////////////////////
   // Tick divider and step timer
   ssq_tick_div #(
      .CYCLES(TICK_CYCLES)
   ) u_div (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick)
   );

   ssq_step_timer u_tmr (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .run(r.st == ssq_run),
      .clear(tmr_clear),
      .dur(r.dur[r.step]),
      .done(done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // APB decode
   assign idx = paddr[5:2];
   assign is_speed = (paddr[11:6] == ssq_speed_base[11:6]) && (idx != 4'hF);
   assign is_dur = (paddr[11:6] == ssq_dur_base[11:6]) && (idx != 4'hF);
   assign wr = psel && penable && pwrite;
   assign start_cmd = wr && (paddr == ssq_cmd_off) && pwdata[ssq_start_pos];
   assign stop_cmd = wr && (paddr == ssq_cmd_off) && pwdata[ssq_stop_pos];
   assign halt = fault || stop_cmd || !r.en;
   assign pready = 1'b1;
   assign seq_on = r.en && (r.st != ssq_idle);

   always_comb
   begin
      prdata = 32'h0000_0000;
      pslverr = 1'b0;
      if (is_speed)
         prdata = 32'(r.speed[idx]);
      else if (is_dur)
         prdata = 32'(r.dur[idx]);
      else
         unique case (paddr)
            ssq_ctrl_off: prdata = 32'({r.mode, r.en, r.mem});
            ssq_cmd_off: prdata = 32'h0000_0000;
            ssq_stat_off: prdata = 32'({fault, r.src, 2'h0, r.st, r.step});
            ssq_dir_off: prdata = 32'(r.dir);
            default: pslverr = psel && penable;
         endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers, step sequencing and source selection
   always_comb
   begin
      next_r = r;
      tmr_clear = 1'b0;
      if (wr)
      begin
         if (is_speed)
            next_r.speed[idx] = (pwdata[SW-1:0] > MAX_FREQ) ? MAX_FREQ : pwdata[SW-1:0];
         else if (is_dur)
            next_r.dur[idx] = (pwdata[13:0] > ssq_dur_max) ? ssq_dur_max : pwdata[13:0];
         else if (paddr == ssq_ctrl_off)
         begin
            next_r.mem = pwdata[ssq_mem_pos];
            next_r.en = pwdata[ssq_en_pos];
            if (pwdata[ssq_mode_pos+2:ssq_mode_pos] <= 3'h4)
               next_r.mode = ssq_mode_t'(pwdata[ssq_mode_pos+2:ssq_mode_pos]);
         end
         else if (paddr == ssq_dir_off)
            next_r.dir = pwdata[15:0];
      end

      unique case (r.st)
         ssq_idle:
            if (start_cmd && r.en && !fault)
               next_r.st = ssq_run;
         ssq_run:
            if (done)
            begin
               if (r.step == ssq_last_step)
               begin
                  unique case (r.mode)
                     ssq_once:
                     begin
                        next_r.st = ssq_idle;
                        next_r.step = 4'h0;
                        tmr_clear = 1'b1;
                     end
                     ssq_repeat:
                     begin
                        next_r.step = 4'h0;
                        tmr_clear = 1'b1;
                     end
                     ssq_keep_last:
                        next_r.st = ssq_hold;
                     default:
                     begin
                        next_r.st = ssq_pause;
                        next_r.last = 1'b1;
                     end
                  endcase
               end
               else if (is_pause(r.mode))
               begin
                  next_r.st = ssq_pause;
                  next_r.last = 1'b0;
               end
               else
               begin
                  next_r.step = r.step + 4'h1;
                  tmr_clear = 1'b1;
               end
            end
         ssq_pause:
            if (out_at_zero)
            begin
               tmr_clear = 1'b1;
               next_r.st = ssq_run;
               next_r.last = 1'b0;
               if (!r.last)
                  next_r.step = r.step + 4'h1;
               else
               begin
                  next_r.step = 4'h0;
                  if (r.mode == ssq_once_pause)
                     next_r.st = ssq_idle;
               end
            end
         ssq_hold:
            next_r.st = ssq_hold;
      endcase

      if ((r.st != ssq_idle) && halt)
      begin
         next_r.st = ssq_idle;
         if (!r.mem)
         begin
            next_r.step = 4'h0;
            next_r.last = 1'b0;
            tmr_clear = 1'b1;
         end
         else
         begin
            next_r.step = r.step;
            next_r.last = r.last;
            tmr_clear = 1'b0;
         end
      end

      next_r.rev = r.en && r.dir[0];
      if (jog_req)
      begin
         next_r.src = ssq_src_jog;
         next_r.freq = jog_freq;
      end
      else if (ext_ms_req)
      begin
         next_r.src = ssq_src_ext;
         next_r.freq = ext_ms_freq;
      end
      else if (seq_on)
      begin
         next_r.src = ssq_src_int;
         next_r.freq = (r.st == ssq_pause) ? '0 : r.speed[r.step];
         next_r.rev = r.dir[r.step + 4'h1];
      end
      else if (pid_req)
      begin
         next_r.src = ssq_src_pid;
         next_r.freq = pid_freq;
      end
      else if (tri_req)
      begin
         next_r.src = ssq_src_tri;
         next_r.freq = tri_freq;
      end
      else if (wind_req)
      begin
         next_r.src = ssq_src_wind;
         next_r.freq = wind_freq;
      end
      else
      begin
         next_r.src = ssq_src_normal;
         next_r.freq = normal_freq;
      end
   end

   // Power-on reset drops any retained step
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         r <= '0;
         r.src <= ssq_src_normal;
         for (int i = 0; i < ssq_steps; i++)
         begin
            r.speed[i] <= SW'(ssq_speed_rst(i));
            r.dur[i] <= ssq_dur_rst(i);
         end
      end
      else
         r <= next_r;

   assign freq_ref = r.freq;
   assign reverse = r.rev;
   assign seq_active = seq_on;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   logic started;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         started <= 1'b0;
      else if ((r.st == ssq_idle) && start_cmd && r.en && !fault)
         started <= 1'b1;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_halt;
      (r.st != ssq_idle) && halt;
   endsequence

   sequence s_pause_end;
      (r.st == ssq_run) && done && !halt && is_pause(r.mode);
   endsequence

   sequence s_pause_quiet;
      s_pause_end ##1 seq_on && !jog_req && !ext_ms_req;
   endsequence

   sequence s_first_start;
      (r.st == ssq_idle) && start_cmd && r.en && !fault && !started;
   endsequence

   mem_off_clear_a: assert property (s_halt ##0 !r.mem |=> r.step == 4'h0)
      else $error("step kept with memory off");
   mem_on_keep_a: assert property (
      s_halt ##0 r.mem |=> (r.step == $past(r.step)) && (r.st == ssq_idle))
      else $error("step lost with memory on");
   power_up_a: assert property (s_first_start |=> r.step == 4'h0)
      else $error("first start not at first step");
   disabled_src_a: assert property (
      presetn && !r.en && !jog_req && !ext_ms_req && !pid_req && !tri_req && !wind_req
      |=> (r.src == ssq_src_normal) && (freq_ref == $past(normal_freq)) && !reverse)
      else $error("disabled sequencer not using normal mode");
   seq_src_a: assert property (
      seq_on && (r.st == ssq_run) && !jog_req && !ext_ms_req
      |=> (r.src == ssq_src_int) && (freq_ref == $past(r.speed[r.step])))
      else $error("step speed not applied");
   jog_wins_a: assert property (jog_req |=> (r.src == ssq_src_jog) && (freq_ref == $past(jog_freq)))
      else $error("jog did not take precedence");
   hold_last_a: assert property ((r.st == ssq_hold) |-> r.step == ssq_last_step)
      else $error("hold state away from last step");
   pause_enter_a: assert property (s_pause_end |=> r.st == ssq_pause)
      else $error("pause state not entered");
   pause_stop_a: assert property (s_pause_quiet |=> freq_ref == '0)
      else $error("pause did not bring reference to zero");
   step_dir_a: assert property (
      seq_on && !jog_req && !ext_ms_req |=> reverse == $past(r.dir[r.step + 4'h1]))
      else $error("step direction bit not applied");
   step_adv_a: assert property (
      (r.st == ssq_run) && done && !halt && !is_pause(r.mode) && (r.step != ssq_last_step)
      |=> r.step == $past(r.step) + 4'h1)
      else $error("step did not advance at end of duration");
endmodule : ssq_sequencer

// *** hw/ssq_step_timer.sv ***
`timescale 1ns/10ps
module ssq_step_timer
   import ssq_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tick,
   input wire logic run,
   input wire logic clear,
   input wire logic [13:0] dur,
   output logic done
);
   typedef struct packed {
      logic [13:0] cnt;
   } ssq_tmr_t;

   ssq_tmr_t r;
   ssq_tmr_t next_r;

   assign done = run && (r.cnt >= dur);
   always_comb
   begin
      next_r = r;
      if (clear)
         next_r.cnt = '0;
      else if (run && tick && !done)
         next_r.cnt = r.cnt + 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         r <= '0;
      else
         r <= next_r;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   timer_clear_a: assert property (clear |=> r.cnt == 14'h0000)
      else $error("step timer not cleared");
   timer_count_a: assert property (
      run && tick && !clear && !done |=> r.cnt == $past(r.cnt) + 14'h0001)
      else $error("step timer missed a tick");
endmodule : ssq_step_timer

// *** hw/ssq_tick_div.sv ***
`timescale 1ns/10ps
module ssq_tick_div
   import ssq_pkg::*;
#(
   parameter int CYCLES = ssq_tick_cycles
)(
   input wire logic pclk,
   input wire logic presetn,
   output logic tick
);
   localparam int CW = $clog2(CYCLES + 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic tick;
   } ssq_div_t;

   ssq_div_t r;
   ssq_div_t next_r;

   always_comb
   begin
      next_r = r;
      next_r.tick = 1'b0;
      if (r.cnt == CW'(CYCLES - 1))
      begin
         next_r.cnt = '0;
         next_r.tick = 1'b1;
      end
      else
         next_r.cnt = r.cnt + 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         r <= '0;
      else
         r <= next_r;

   assign tick = r.tick;
endmodule : ssq_tick_div

// *** include/ssq_pkg.sv ***
package ssq_pkg;
   localparam int ssq_steps = 15;
   localparam logic [11:0] ssq_ctrl_off = 12'h000;
   localparam logic [11:0] ssq_cmd_off = 12'h004;
   localparam logic [11:0] ssq_stat_off = 12'h008;
   localparam logic [11:0] ssq_dir_off = 12'h00C;
   localparam logic [11:0] ssq_speed_base = 12'h040;
   localparam logic [11:0] ssq_dur_base = 12'h080;
   localparam int ssq_mem_pos = 0;
   localparam int ssq_en_pos = 1;
   localparam int ssq_mode_pos = 2;
   localparam int ssq_start_pos = 0;
   localparam int ssq_stop_pos = 1;
   localparam logic [3:0] ssq_last_step = 4'hE;
   localparam logic [13:0] ssq_dur_max = 14'h270F;
   localparam logic [13:0] ssq_dur_long = 14'h0064;
   localparam int ssq_long_steps = 5;
   localparam logic [15:0] ssq_speed_lo = 16'h03E8;
   localparam logic [15:0] ssq_speed_inc = 16'h01F4;
   localparam int ssq_ramp_steps = 9;
   localparam int ssq_clk_ns = 10;
   localparam int ssq_tick_ns = 100_000_000;
   localparam int ssq_tick_cycles = ssq_tick_ns / ssq_clk_ns;

   typedef enum logic [2:0] {
      ssq_once = 3'h0,
      ssq_once_pause = 3'h1,
      ssq_repeat = 3'h2,
      ssq_repeat_pause = 3'h3,
      ssq_keep_last = 3'h4
   } ssq_mode_t;

   typedef enum logic [1:0] {
      ssq_idle = 2'h0,
      ssq_run = 2'h1,
      ssq_pause = 2'h3,
      ssq_hold = 2'h2
   } ssq_state_t;

   typedef enum logic [2:0] {
      ssq_src_jog = 3'h0,
      ssq_src_ext = 3'h1,
      ssq_src_int = 3'h2,
      ssq_src_pid = 3'h3,
      ssq_src_tri = 3'h4,
      ssq_src_wind = 3'h5,
      ssq_src_normal = 3'h6
   } ssq_src_t;

   function automatic logic [15:0] ssq_speed_rst(input int i);
      return (i < ssq_ramp_steps) ? ssq_speed_lo + 16'(i) * ssq_speed_inc : ssq_speed_lo;
   endfunction : ssq_speed_rst

   function automatic logic [13:0] ssq_dur_rst(input int i);
      return (i < ssq_long_steps) ? ssq_dur_long : 14'h0000;
   endfunction : ssq_dur_rst
endpackage : ssq_pkg

// *** sim/speed_step_sequencer_tb_top.sv ***
`timescale 1ns/10ps
module speed_step_sequencer_tb_top
   import ssq_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic fault, out_at_zero, reverse, seq_active;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [6:0] req;
   logic [15:0] src_f [7];
   logic [15:0] freq_ref;
   logic [5:0] end_st [5] = '{6'h00, 6'h00, 6'h10, 6'h10, 6'h2E};
   int fail_count = 0;
   int n_compared = 0;
   int seed = 75199;
   int spd [15];
   int dir;
   int f;

   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   ssq_sequencer #(.SW(16), .TICK_CYCLES(4)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fault(fault), .out_at_zero(out_at_zero), .jog_req(req[0]), .jog_freq(src_f[0]),
      .ext_ms_req(req[1]), .ext_ms_freq(src_f[1]), .pid_req(req[3]), .pid_freq(src_f[3]),
      .tri_req(req[4]), .tri_freq(src_f[4]), .wind_req(req[5]), .wind_freq(src_f[5]),
      .normal_freq(src_f[6]), .freq_ref(freq_ref), .reverse(reverse),
      .seq_active(seq_active));

   ssq_drive_model #(.SW(16), .RAMP(300)) drive (
      .pclk(pclk), .presetn(presetn), .freq_ref(freq_ref), .out_at_zero(out_at_zero));

////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("compared %0d failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_of_test

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Reads status until state and step match, bounded
   task automatic poll(input logic [5:0] v);
      int n;
      n = 0;
      do
      begin
         apb(1'b0, ssq_stat_off, 32'h0);
         n++;
      end
      while (rd[5:0] !== v && n < 500);
      check("status", v, rd[5:0]);
   endtask : poll

////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (60000) @(posedge pclk);
      fail_count++;
      end_of_test();
   end

   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      fault = 1'b0;
      req = 7'h00;
      for (int i = 0; i < 7; i++)
         src_f[i] = 16'(i * 1000 + 7);
      presetn = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < ssq_steps; i++)
      begin
         apb(1'b0, ssq_speed_base + 12'(4 * i), 32'h0);
         check("speed reset", (i < 9) ? 1000 + 500 * i : 1000, rd);
         apb(1'b0, ssq_dur_base + 12'(4 * i), 32'h0);
         check("dur reset", (i < 5) ? 100 : 0, rd);
      end
      $display("reset values done");
      apb(1'b1, ssq_dir_off, 32'hFFFF);
      apb(1'b1, ssq_ctrl_off, 32'h8);
      apb(1'b1, ssq_cmd_off, 32'h1);
      repeat (2) @(posedge pclk);
      check("active", 0, seq_active);
      check("normal freq", src_f[6], freq_ref);
      check("reverse", 0, reverse);
      apb(1'b0, 12'h010, 32'h0);
      check("unmapped", 1, err);
      apb(1'b1, ssq_ctrl_off, 32'h14);
      apb(1'b0, ssq_ctrl_off, 32'h0);
      check("mode refused", 32'h8, rd);
      $display("disabled done");
      dir = $random(seed) & 32'h7FFF;
      apb(1'b1, ssq_dir_off, dir);
      apb(1'b1, ssq_speed_base, 32'hFFFF);
      apb(1'b0, ssq_speed_base, 32'h0);
      check("speed clamp", 40000, rd);
      spd[0] = 40000;
      apb(1'b1, ssq_dur_base, 32'd20);
      for (int i = 1; i < ssq_steps; i++)
      begin
         spd[i] = {$random(seed)} % 40001;
         apb(1'b1, ssq_speed_base + 12'(4 * i), spd[i]);
         apb(1'b1, ssq_dur_base + 12'(4 * i), 3 + {$random(seed)} % 3);
      end
      for (int m = 0; m < 5; m++)
      begin
         apb(1'b1, ssq_ctrl_off, 32'(m << 2) | 32'h2);
         apb(1'b1, ssq_cmd_off, 32'h1);
         for (int k = 0; k < ssq_steps; k++)
         begin
            poll({2'b01, 4'(k)});
            repeat (2) @(posedge pclk);
            check("step freq", spd[k], freq_ref);
            check("step dir", (dir >> (k + 1)) & 1, reverse);
            if (m % 2 == 1 && k == 0)
            begin
               poll(6'h30);
               repeat (2) @(posedge pclk);
               check("pause freq", 0, freq_ref);
            end
         end
         poll(end_st[m]);
         if (m < 4)
            apb(1'b1, ssq_cmd_off, 32'h2);
         $display("cycle mode %0d done", m);
      end
      for (int p = 0; p < 7; p++)
      begin
         if (p == 3)
            apb(1'b1, ssq_cmd_off, 32'h2);
         req <= 7'h7F << p;
         repeat (2) @(posedge pclk);
         f = (p == 2) ? spd[14] : src_f[p];
         check("source freq", f, freq_ref);
         check("source dir", (p == 2) ? (dir >> 15) & 1 : dir & 1, reverse);
         apb(1'b0, ssq_stat_off, 32'h0);
         check("source", p, rd[10:8]);
      end
      req <= 7'h00;
      $display("priority done");
      apb(1'b1, ssq_ctrl_off, 32'h3);
      apb(1'b1, ssq_cmd_off, 32'h1);
      poll(6'h13);
      fault <= 1'b1;
      apb(1'b0, ssq_stat_off, 32'h0);
      check("fault keeps step", 6'h03, rd[5:0]);
      apb(1'b1, ssq_cmd_off, 32'h1);
      repeat (2) @(posedge pclk);
      check("start in fault", 0, seq_active);
      fault <= 1'b0;
      apb(1'b1, ssq_cmd_off, 32'h1);
      apb(1'b0, ssq_stat_off, 32'h0);
      check("resume", 1, rd[3:0] >= 4'h3 && rd[5:4] == 2'b01);
      apb(1'b1, ssq_ctrl_off, 32'h2);
      apb(1'b1, ssq_cmd_off, 32'h2);
      apb(1'b0, ssq_stat_off, 32'h0);
      check("stop clears", 6'h00, rd[5:0]);
      apb(1'b1, ssq_ctrl_off, 32'h3);
      apb(1'b1, ssq_cmd_off, 32'h1);
      poll(6'h13);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ssq_stat_off, 32'h0);
      check("power up step", 6'h00, rd[5:0]);
      apb(1'b0, ssq_ctrl_off, 32'h0);
      check("power up ctrl", 0, rd);
      apb(1'b1, ssq_ctrl_off, 32'h3);
      apb(1'b1, ssq_cmd_off, 32'h1);
      apb(1'b0, ssq_stat_off, 32'h0);
      check("power up start", 6'h10, rd[5:0]);
      $display("memory done");
      end_of_test();
   end
endmodule : speed_step_sequencer_tb_top

// *** sim/ssq_drive_model.sv ***
`timescale 1ns/10ps
module ssq_drive_model
   import ssq_pkg::*;
#(
   parameter int SW = 16,
   parameter int RAMP = 300
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [SW-1:0] freq_ref,
   output logic out_at_zero
);
   int speed;
   int target;
   assign target = int'(freq_ref);
   // Output stage ramps toward the reference at a fixed rate
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         speed <= 0;
      else if (speed > target)
         speed <= (speed - RAMP > target) ? speed - RAMP : target;
      else
         speed <= (speed + RAMP < target) ? speed + RAMP : target;
   end
   assign out_at_zero = (speed == 0);
endmodule : ssq_drive_model
